/* rtl/cas_flags_pkg.sv */
// Behaviour
// - First change register flags timeslots 0-7, bit 7 lowest slot, bit 0 highest.
// - Second change register flags timeslots 8-15, bit 7 slot 8, bit 0 slot 15.
// - Third change register flags timeslots 16-23, bit 7 slot 16, bit 0 slot 23.
// - A flag reads 1 if its slot signaling changed since last read, else 0.
// - Reading a change register returns its flags, then clears them, except a flag set by a change on the clearing edge.
// - Timeslot 0 flag never sets; that slot carries framing, not signaling.
// - All flags stay cleared and inactive unless CAS mode is enabled.
package cas_flags_pkg;

	localparam int SLOT_W     = 5;
	localparam int ABCD_W     = 4;
	localparam int NUM_SLOTS  = 32;
	localparam int FLAG_SLOTS = 24;
	localparam int GROUP_W    = 8;
	localparam int NUM_GROUPS = 3;
	localparam int OFFS_W     = 8;

	// Register byte offsets
	localparam logic [OFFS_W-1:0] OFFS_CHG_0_7   = 8'h00;
	localparam logic [OFFS_W-1:0] OFFS_CHG_8_15  = 8'h04;
	localparam logic [OFFS_W-1:0] OFFS_CHG_16_23 = 8'h08;
	localparam logic [OFFS_W-1:0] OFFS_CTRL      = 8'h0c;
	localparam logic [OFFS_W-1:0] OFFS_INT_STS   = 8'h10;
	localparam logic [OFFS_W-1:0] OFFS_INT_MASK  = 8'h14;

	// Field positions and reset values
	localparam int CTRL_CAS_EN_BIT = 0;
	localparam logic [FLAG_SLOTS-1:0] FLAGS_RST = 24'h000000;
	localparam logic [NUM_GROUPS-1:0] INT_RST   = 3'h0;
	localparam logic                  CTRL_RST  = 1'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		logic [ABCD_W-1:0] abcd;
	} sig_in_t;

endpackage

/* rtl/sig_value_mem.sv */
`timescale 1ns/1ps
module sig_value_mem #(
	parameter int DEPTH  = 32,
	parameter int WIDTH  = 4,
	parameter int ADDR_W = 5
) (
	input  wire logic              clk_i,     // System clock
	input  wire logic              rst_i,     // Sync reset
	input  wire logic              wr_en_i,   // Write strobe
	input  wire logic [ADDR_W-1:0] wr_addr_i, // Write slot
	input  wire logic [WIDTH-1:0]  wr_data_i, // Write value
	input  wire logic              rd_en_i,   // Read strobe
	input  wire logic [ADDR_W-1:0] rd_addr_i, // Read slot
	output logic      [WIDTH-1:0]  rd_data_o  // Registered read data
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	// Read returns the old word on a same-address write
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_q <= '0;
		end else if (rd_en_i) begin
			rd_data_q <= mem[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_q;

endmodule

/* rtl/e1_cas_change_flags.sv */
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module e1_cas_change_flags (
	input  wire logic                   SYS_CLK_I,   // 100 MHz clock
	input  wire logic                   RST_I,       // Sync reset, high
	input  wire logic                   HSEL_I,      // AHB slave select
	input  wire logic [31:0]            HADDR_I,     // AHB address
	input  wire logic [1:0]             HTRANS_I,    // AHB transfer type
	input  wire logic                   HWRITE_I,    // AHB write
	input  wire logic [2:0]             HSIZE_I,     // AHB size
	input  wire logic [31:0]            HWDATA_I,    // AHB write data
	input  wire logic                   HREADY_I,    // AHB bus ready
	output logic      [31:0]            HRDATA_O,    // AHB read data
	output logic                        HREADYOUT_O, // AHB slave ready
	output logic      [1:0]             HRESP_O,     // AHB response
	input  wire logic                   SIG_VALID_I, // New CAS value pulse
	input  wire cas_flags_pkg::sig_in_t SIG_I,       // Slot and abcd bits
	output logic                        IRQ_O        // Interrupt level
);
	import cas_flags_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Slot s of group g lands on bit 7-(s mod 8)
	function automatic logic [GROUP_W-1:0] grp_bits(
		input logic [FLAG_SLOTS-1:0] f,
		input int                    g
	);
		logic [GROUP_W-1:0] r;
		r = '0;
		for (int i = 0; i < GROUP_W; i++) begin
			r[GROUP_W-1-i] = f[g*GROUP_W+i];
		end
		return r;
	endfunction

	function automatic logic [FLAG_SLOTS-1:0] clr_mask(
		input logic [OFFS_W-1:0] a
	);
		logic [FLAG_SLOTS-1:0] m;
		m = '0;
		if (a == OFFS_CHG_0_7) begin
			m = 24'h0000ff;
		end else if (a == OFFS_CHG_8_15) begin
			m = 24'h00ff00;
		end else if (a == OFFS_CHG_16_23) begin
			m = 24'hff0000;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [FLAG_SLOTS-1:0] flags_q, flags_d;
	logic [NUM_SLOTS-1:0]  seen_q, seen_d;
	logic                  cas_en_q;
	logic [NUM_GROUPS-1:0] sts_q, sts_d;
	logic [NUM_GROUPS-1:0] mask_q;
	logic                  cmp_vld_q;
	sig_in_t               cmp_q;
	logic                  byp_q;
	logic [ABCD_W-1:0]     byp_data_q;
	logic                  rd_pend_q;
	logic [OFFS_W-1:0]     rd_addr_q;
	logic                  wr_pend_q;
	logic [OFFS_W-1:0]     wr_addr_q;
	logic [31:0]           hrdata_q;
	logic                  hreadyout_q;
	logic                  irq_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire rd_acc = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ)
		&& !HWRITE_I;
	wire wr_acc = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ)
		&& HWRITE_I;
	wire wr_ctrl = wr_pend_q && (wr_addr_q == OFFS_CTRL);
	wire wr_sts  = wr_pend_q && (wr_addr_q == OFFS_INT_STS);
	wire wr_mask = wr_pend_q && (wr_addr_q == OFFS_INT_MASK);

	wire [FLAG_SLOTS-1:0] rd_clr = rd_pend_q ? clr_mask(rd_addr_q)
		: 24'h000000;

	// Unmapped offsets read as zero
	wire [31:0] rd_word =
		(rd_addr_q == OFFS_CHG_0_7)   ? {24'h0, grp_bits(flags_q, 0)} :
		(rd_addr_q == OFFS_CHG_8_15)  ? {24'h0, grp_bits(flags_q, 1)} :
		(rd_addr_q == OFFS_CHG_16_23) ? {24'h0, grp_bits(flags_q, 2)} :
		(rd_addr_q == OFFS_CTRL)      ? {31'h0, cas_en_q}             :
		(rd_addr_q == OFFS_INT_STS)   ? {29'h0, sts_q}                :
		(rd_addr_q == OFFS_INT_MASK)  ? {29'h0, mask_q}               :
		32'h0;

	////////////////////////////////////////////////////////////////////////
	// Signaling compare

	wire [ABCD_W-1:0] mem_rd;

	sig_value_mem #(
		.DEPTH  (NUM_SLOTS),
		.WIDTH  (ABCD_W),
		.ADDR_W (SLOT_W)
	) u_sig_mem (
		.clk_i     (SYS_CLK_I),
		.rst_i     (RST_I),
		.wr_en_i   (cmp_vld_q),
		.wr_addr_i (cmp_q.slot),
		.wr_data_i (cmp_q.abcd),
		.rd_en_i   (SIG_VALID_I),
		.rd_addr_i (SIG_I.slot),
		.rd_data_o (mem_rd)
	);

	// Bypass covers a slot written in the very cycle it is read back
	wire [ABCD_W-1:0] prev_abcd = byp_q ? byp_data_q : mem_rd;

	// First value after enable only primes the store
	wire slot_live = (cmp_q.slot != 5'h00)
		&& (cmp_q.slot < 5'(FLAG_SLOTS));
	wire chg = cmp_vld_q && cas_en_q && seen_q[cmp_q.slot] && slot_live
		&& (prev_abcd != cmp_q.abcd);

	wire [FLAG_SLOTS-1:0] set_mask = chg ? (24'h000001 << cmp_q.slot)
		: 24'h000000;
	wire [NUM_SLOTS-1:0]  seen_set = cmp_vld_q ? (32'h1 << cmp_q.slot)
		: 32'h0;

	wire [NUM_GROUPS-1:0] grp_evt = {|set_mask[23:16], |set_mask[15:8],
		|set_mask[7:0]};

	// Set wins over the read clear so no change is lost
	assign flags_d = cas_en_q ? ((flags_q & ~rd_clr) | set_mask)
		: FLAGS_RST;
	assign seen_d  = cas_en_q ? (seen_q | seen_set) : '0;
	assign sts_d   = (sts_q & ~(wr_sts ? HWDATA_I[2:0] : 3'h0)) | grp_evt;

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cmp_vld_q  <= 1'b0;
			cmp_q      <= '0;
			byp_q      <= 1'b0;
			byp_data_q <= '0;
		end else begin
			cmp_vld_q  <= SIG_VALID_I;
			cmp_q      <= SIG_I;
			byp_q      <= SIG_VALID_I && cmp_vld_q
				&& (cmp_q.slot == SIG_I.slot);
			byp_data_q <= cmp_q.abcd;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			flags_q <= FLAGS_RST;
			seen_q  <= '0;
			sts_q   <= INT_RST;
		end else begin
			flags_q <= flags_d;
			seen_q  <= seen_d;
			sts_q   <= sts_d;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cas_en_q <= CTRL_RST;
			mask_q   <= INT_RST;
		end else begin
			if (wr_ctrl) begin
				cas_en_q <= HWDATA_I[CTRL_CAS_EN_BIT];
			end
			if (wr_mask) begin
				mask_q <= HWDATA_I[2:0];
			end
		end
	end

	// One wait state on reads so a write just before is visible
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rd_pend_q   <= 1'b0;
			rd_addr_q   <= '0;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= '0;
			hreadyout_q <= 1'b1;
		end else begin
			rd_pend_q   <= rd_acc;
			wr_pend_q   <= wr_acc;
			hreadyout_q <= !rd_acc;
			if (rd_acc) begin
				rd_addr_q <= HADDR_I[OFFS_W-1:0];
			end
			if (wr_acc) begin
				wr_addr_q <= HADDR_I[OFFS_W-1:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			hrdata_q <= 32'h0;
			irq_q    <= 1'b0;
		end else begin
			irq_q <= |(sts_q & mask_q);
			if (rd_pend_q) begin
				hrdata_q <= rd_word;
			end
		end
	end

	assign HRDATA_O    = hrdata_q;
	assign HREADYOUT_O = hreadyout_q;
	assign HRESP_O     = HRESP_OKAY;
	assign IRQ_O       = irq_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	wire rd_chg0 = rd_pend_q && (rd_addr_q == OFFS_CHG_0_7);
	wire rd_chg1 = rd_pend_q && (rd_addr_q == OFFS_CHG_8_15);
	wire rd_chg2 = rd_pend_q && (rd_addr_q == OFFS_CHG_16_23);

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);

	a_map_low_group: assert property (
		rd_chg0 |=> HRDATA_O[6] == $past(flags_q[1])
			&& HRDATA_O[0] == $past(flags_q[7]))
		else $error("group 0-7 bit order wrong");

	a_map_mid_group: assert property (
		rd_chg1 |=> HRDATA_O[7] == $past(flags_q[8])
			&& HRDATA_O[0] == $past(flags_q[15]))
		else $error("group 8-15 bit order wrong");

	a_map_high_group: assert property (
		rd_chg2 |=> HRDATA_O[7] == $past(flags_q[16])
			&& HRDATA_O[0] == $past(flags_q[23]))
		else $error("group 16-23 bit order wrong");

	a_change_sets_flag: assert property (
		cmp_vld_q && cas_en_q && cmp_q.slot == 5'h0a && seen_q[10]
			&& prev_abcd != cmp_q.abcd
		|=> flags_q[10] ##1 (flags_q[10] || $past(rd_chg1)
			|| !$past(cas_en_q)))
		else $error("changed slot 10 not flagged");

	a_read_clears_group: assert property (
		rd_chg1 && !(|set_mask[15:8]) |=> flags_q[15:8] == 8'h00)
		else $error("read did not clear group 8-15");

	a_slot0_never_set: assert property (
		!flags_q[0] && (!HRDATA_O[7] || !$past(rd_chg0)))
		else $error("timeslot 0 flag set");

	a_cas_off_clear: assert property (
		!cas_en_q |=> flags_q == 24'h000000 && seen_q == 32'h0)
		else $error("flags active with CAS off");

	a_set_wins_read: assert property (
		rd_pend_q && set_mask != 24'h000000 && cas_en_q
		|=> (flags_q & $past(set_mask)) == $past(set_mask))
		else $error("change lost under read");

	a_read_wait: assert property (
		rd_acc |=> !HREADYOUT_O ##1 HREADYOUT_O)
		else $error("read wait state wrong");

	// Priming or a repeated value must not raise any flag
	a_prime_quiet: assert property (
		cmp_vld_q && !seen_q[cmp_q.slot]
		|=> (flags_q & ~$past(flags_q)) == 24'h000000)
		else $error("primed slot raised a flag");

	a_same_value_quiet: assert property (
		cmp_vld_q && prev_abcd == cmp_q.abcd
		|=> (flags_q & ~$past(flags_q)) == 24'h000000)
		else $error("unchanged value raised a flag");

	a_write_no_wait: assert property (
		wr_acc |=> HREADYOUT_O)
		else $error("write stalled the bus");

	// Set wins over a write-one clear in the same cycle
	a_status_sticky: assert property (
		grp_evt != 3'h0 |=> (sts_q & $past(grp_evt)) == $past(grp_evt))
		else $error("group event lost from status");

	a_irq_masked: assert property (
		(sts_q & mask_q) == 3'h0 |=> !IRQ_O)
		else $error("interrupt without unmasked status");

	c_change_seen: cover property (chg);
	c_change_on_read: cover property (chg && rd_pend_q);
	c_read_nonzero: cover property (rd_chg0 ##1 HRDATA_O != 32'h0);
	c_irq_raised: cover property (!IRQ_O ##1 IRQ_O);
	c_slot0_value: cover property (cmp_vld_q && cmp_q.slot == 5'h00
		&& seen_q[0]);

endmodule

/* bench/cas_source.sv */
`timescale 1ns/1ps
module cas_source (
	input  wire logic              clk_i,   // Framer clock
	output logic                   valid_o, // New value pulse
	output cas_flags_pkg::sig_in_t sig_o    // Slot and bits
);
	import cas_flags_pkg::*;
	initial begin
		valid_o = 1'b0;
		sig_o   = '0;
	end
	////////////////////////////////////////////////////////////////
	// Idle bus shows inverted data so a stale value never passes
	task automatic send(input logic [4:0] s, input logic [3:0] v);
		@(posedge clk_i);
		valid_o <= 1'b1;
		sig_o   <= {s, v};
		@(posedge clk_i);
		valid_o <= 1'b0;
		sig_o   <= sig_in_t'(~sig_o);
	endtask
endmodule

/* bench/e1_cas_change_flags_bench.sv */
`timescale 1ns/1ps
module e1_cas_change_flags_bench;
	import cas_flags_pkg::*;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic [1:0]  trans = 2'h0;
	logic [31:0] addr  = 32'h0;
	logic        wr    = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic        rdy;
	logic [1:0]  resp;
	logic        irq;
	logic        sv;
	sig_in_t     sig;
	int          n_mismatch = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;
	always #5 clk = ~clk;
	cas_source src (.clk_i(clk), .valid_o(sv), .sig_o(sig));
	e1_cas_change_flags dut (
		.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1),
		.HADDR_I(addr), .HTRANS_I(trans), .HWRITE_I(wr),
		.HSIZE_I(3'h2), .HWDATA_I(wdata), .HREADY_I(rdy),
		.HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(resp),
		.SIG_VALID_I(sv), .SIG_I(sig), .IRQ_O(irq)
	);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		trans <= HTRANS_NONSEQ;
		addr  <= {24'h0, a};
		wr    <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		trans <= 2'h0;
		wdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = rdata;
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Whole run needs under two hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a <= 32; a += 4)
			rchk("reset", 8'(a), 32'h0);
		chk("resp", {30'h0, resp}, {30'h0, HRESP_OKAY});
		$display("test reset done");
		src.send(5'd9, 4'h3);
		src.send(5'd9, 4'h5);
		rchk("cas off", OFFS_CHG_8_15, 32'h0);
		$display("test disabled done");
		xfer(1'b1, OFFS_CTRL, 32'h1);
		// First value per slot only primes the store
		for (int s = 0; s < 24; s++)
			src.send(5'(s), 4'h0);
		src.send(5'd1, 4'h5);
		src.send(5'd8, 4'h5);
		src.send(5'd23, 4'h5);
		rchk("grp0", OFFS_CHG_0_7, 32'h40);
		rchk("grp1", OFFS_CHG_8_15, 32'h80);
		rchk("grp2", OFFS_CHG_16_23, 32'h01);
		rchk("cleared", OFFS_CHG_8_15, 32'h0);
		src.send(5'd1, 4'h5);
		src.send(5'd0, 4'h9);
		src.send(5'd7, 4'h9);
		rchk("slot0", OFFS_CHG_0_7, 32'h01);
		$display("test flags done");
		rchk("status", OFFS_INT_STS, 32'h7);
		chk("irq masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, OFFS_INT_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq on", {31'h0, irq}, 32'h1);
		xfer(1'b1, OFFS_INT_STS, 32'h7);
		rchk("status clr", OFFS_INT_STS, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		$display("test irq done");
		// Change lands on the very edge that clears the register
		fork
			xfer(1'b0, OFFS_CHG_8_15, 32'h0);
			src.send(5'd10, 4'h6);
		join
		chk("pre collision", rd, 32'h0);
		rchk("kept", OFFS_CHG_8_15, 32'h20);
		$display("test collision done");
		final_report();
	end
endmodule
